// ---- mpcrf_pkg.sv ----
// constants for the PHY management, receive filter and receive burst registers
// assumes byte-wide register access at the printed I/O offsets
package mpcrf_pkg;

	// ==========================================
	// register offsets
	localparam logic [7:0] MPCRF_OFF_BURST = 8'h14;
	localparam logic [7:0] MPCRF_OFF_PHY = 8'h5E;
	localparam logic [7:0] MPCRF_OFF_FILTER = 8'h5C;

	// ==========================================
	// reset values and write masks
	localparam logic [7:0] MPCRF_RST_BURST = 8'h08;
	localparam logic [7:0] MPCRF_RST_PHY = 8'h00;
	localparam logic [7:0] MPCRF_RST_FILTER = 8'h00;
	localparam logic [7:0] MPCRF_WMASK_PHY = 8'h17;
	localparam logic [7:0] MPCRF_WMASK_FILTER = 8'h3F;
	localparam logic [7:0] MPCRF_ZERO8 = 8'h00;

	// ==========================================
	// management control field positions
	localparam int MPCRF_B_CLK = 0;
	localparam int MPCRF_B_DATA = 1;
	localparam int MPCRF_B_DIR = 2;
	localparam int MPCRF_B_RSV = 3;
	localparam int MPCRF_B_POL = 4;
	localparam int MPCRF_B_DUPLEX = 5;
	localparam int MPCRF_B_SPEED = 6;
	localparam int MPCRF_B_LINK = 7;

	// ==========================================
	// receive filter field positions
	localparam int MPCRF_F_STATION = 0;
	localparam int MPCRF_F_GROUP = 1;
	localparam int MPCRF_F_BCAST = 2;
	localparam int MPCRF_F_PROMISC = 3;
	localparam int MPCRF_F_HASH = 4;
	localparam int MPCRF_F_IPGRP = 5;
	localparam int MPCRF_F_WIDTH = 6;
	localparam int MPCRF_DA_GROUP_BIT = 40;
	localparam logic [23:0] MPCRF_IP_GROUP_PREFIX = 24'h01005E;
	localparam logic [47:0] MPCRF_ALL_ONES_DA = 48'hFFFFFFFFFFFF;

	// ==========================================
	// burst request sizing
	localparam int MPCRF_FIFO_W = 13;
	localparam int MPCRF_UNIT_SHIFT = 5;
	localparam logic [7:0] MPCRF_MIN_BURST = 8'h08;

	typedef logic [MPCRF_F_WIDTH-1:0] mpcrf_mode_t;

endpackage

// ---- mpcrf_filt_if.sv ----
// signals between the register bank and its destination address filter
// assumes one clock domain shared by both ends
interface mpcrf_filt_if;
	import mpcrf_pkg::*;

	logic [47:0] da;
	logic da_valid;
	logic [47:0] station;
	logic hash_hit;
	mpcrf_mode_t mode;
	logic accept;
	logic accept_valid;

	modport bank (output da, da_valid, station, hash_hit, mode, input accept, accept_valid);
	modport filt (input da, da_valid, station, hash_hit, mode, output accept, accept_valid);
endinterface

// ---- mpcrf_filter.sv ----
// destination address filter: one registered verdict per presented address
// assumes the hash lookup result arrives together with the address
module mpcrf_filter
	import mpcrf_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	mpcrf_filt_if.filt fi
);

	logic is_bcast;
	logic is_group;
	logic is_ip_group;
	logic is_station;
	logic next_accept;

	assign is_bcast = (fi.da == MPCRF_ALL_ONES_DA);
	assign is_group = fi.da[MPCRF_DA_GROUP_BIT];
	assign is_ip_group = (fi.da[47:24] == MPCRF_IP_GROUP_PREFIX);
	assign is_station = (fi.da == fi.station);

	// any enabled criterion is enough
	always_comb begin
		next_accept = (fi.mode[MPCRF_F_STATION] && is_station)
			|| (fi.mode[MPCRF_F_GROUP] && is_group)
			|| (fi.mode[MPCRF_F_BCAST] && is_bcast)
			|| fi.mode[MPCRF_F_PROMISC]
			|| (fi.mode[MPCRF_F_HASH] && fi.hash_hit)
			|| (fi.mode[MPCRF_F_IPGRP] && is_ip_group);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fi.accept <= 1'b0;
			fi.accept_valid <= 1'b0;
		end else begin
			fi.accept_valid <= fi.da_valid;
			if (fi.da_valid) begin
				fi.accept <= next_accept;
			end
		end
	end

	// ==========================================
	// checks
	property p_promisc;
		@(posedge clk) disable iff (!resetn)
		fi.da_valid && fi.mode[MPCRF_F_PROMISC] |=> fi.accept && fi.accept_valid;
	endproperty
	a_promisc: assert property (p_promisc) else $error("promiscuous frame rejected");

	property p_ip_group;
		@(posedge clk) disable iff (!resetn)
		fi.da_valid && fi.mode == mpcrf_mode_t'(1 << MPCRF_F_IPGRP)
			|=> fi.accept == $past(is_ip_group);
	endproperty
	a_ip_group: assert property (p_ip_group) else $error("ip group verdict wrong");

	property p_none;
		@(posedge clk) disable iff (!resetn)
		fi.da_valid && fi.mode == '0 |=> !fi.accept;
	endproperty
	a_none: assert property (p_none) else $error("frame accepted with no criterion");

	c_bcast: cover property (@(posedge clk) disable iff (!resetn)
		fi.da_valid && is_bcast && fi.mode[MPCRF_F_BCAST] ##1 fi.accept);
endmodule

// ---- mpcrf_bank.sv ----
// PHY management, receive filter select and receive burst threshold registers
// assumes byte-wide register reads and writes synchronous to CLK, one per cycle
//
// Contract
// - management clock pin follows control bit 0 directly
// - control bit 1 is the management data line, out and in
// - with direction bit set, data line carries the written data bit
// - with direction bit clear, line released and read returns PHY level
// - sense bit 4 at zero makes PHY duplex indication active low
// - read-only bit 5 is one in full duplex, zero in half
// - read-only bit 6 is one at 100Mbps, zero at 10Mbps
// - read-only bit 7 is one while link is up
// - filter bit 0 accepts frames matching the 48-bit station address
// - filter bit 1 accepts every group frame including broadcast
// - filter bit 2 accepts every broadcast frame
// - filter bit 3 accepts every frame
// - filter bit 4 accepts frames passing the hash table
// - filter bit 5 accepts destinations beginning 01:00:5e
// - request receive DMA when FIFO bytes exceed threshold times 32
// - request also when FIFO bytes exceed the descriptor frame length
// - threshold below 0x08 acts as 0x08
// - urgent request overrides threshold and raises a request
module mpcrf_bank
	import mpcrf_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic MDC,
	input wire logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE,
	input wire logic PHY_DUPLEX,
	input wire logic PHY_SPEED,
	input wire logic PHY_LINK,
	input wire logic [47:0] OWN_MAC_ADDRESS,
	input wire logic [47:0] RX_DA,
	input wire logic RX_DA_VALID,
	input wire logic GROUP_HASH_HIT,
	output logic RX_ACCEPT,
	output logic RX_ACCEPT_VALID,
	input wire logic [MPCRF_FIFO_W-1:0] RX_FIFO_USED,
	input wire logic [MPCRF_FIFO_W-1:0] DESCRIPTOR_FRAME_LENGTH,
	input wire logic RX_URGENT_REQ,
	output logic RX_DMA_REQ
);

	// ==========================================
	// register storage
	logic [7:0] phy_ctrl;
	mpcrf_mode_t filter_mode;
	logic [7:0] burst_thresh;

	logic wr_phy;
	logic wr_filter;
	logic wr_burst;

	assign wr_phy = REG_WR && (REG_ADDR == MPCRF_OFF_PHY);
	assign wr_filter = REG_WR && (REG_ADDR == MPCRF_OFF_FILTER);
	assign wr_burst = REG_WR && (REG_ADDR == MPCRF_OFF_BURST);

	// only clock, data, direction and sense bits are stored
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			phy_ctrl <= MPCRF_RST_PHY;
		end else if (wr_phy) begin
			phy_ctrl <= REG_WDATA & MPCRF_WMASK_PHY;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			filter_mode <= MPCRF_RST_FILTER[MPCRF_F_WIDTH-1:0];
		end else if (wr_filter) begin
			filter_mode <= REG_WDATA[MPCRF_F_WIDTH-1:0];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			burst_thresh <= MPCRF_RST_BURST;
		end else if (wr_burst) begin
			burst_thresh <= REG_WDATA;
		end
	end

	// ==========================================
	// management pins
	// pins update on the same edge that stores the control byte
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			MDC <= 1'b0;
			MDIO_O <= 1'b0;
			MDIO_OE <= 1'b0;
		end else if (wr_phy) begin
			MDC <= REG_WDATA[MPCRF_B_CLK];
			MDIO_O <= REG_WDATA[MPCRF_B_DATA];
			MDIO_OE <= REG_WDATA[MPCRF_B_DIR];
		end
	end

	// ==========================================
	// status view
	logic full_duplex_flag;
	logic data_view;
	logic [7:0] phy_view;

	// sense bit 0: the PHY pulls the indication low for full duplex
	assign full_duplex_flag = phy_ctrl[MPCRF_B_POL] ? PHY_DUPLEX : !PHY_DUPLEX;
	assign data_view = phy_ctrl[MPCRF_B_DIR] ? phy_ctrl[MPCRF_B_DATA] : MDIO_I;

	always_comb begin
		phy_view = MPCRF_ZERO8;
		phy_view[MPCRF_B_CLK] = phy_ctrl[MPCRF_B_CLK];
		phy_view[MPCRF_B_DATA] = data_view;
		phy_view[MPCRF_B_DIR] = phy_ctrl[MPCRF_B_DIR];
		phy_view[MPCRF_B_POL] = phy_ctrl[MPCRF_B_POL];
		phy_view[MPCRF_B_DUPLEX] = full_duplex_flag;
		phy_view[MPCRF_B_SPEED] = PHY_SPEED;
		phy_view[MPCRF_B_LINK] = PHY_LINK;
	end

	// ==========================================
	// read port
	logic [7:0] next_rdata;

	always_comb begin
		case (REG_ADDR)
			MPCRF_OFF_PHY: next_rdata = phy_view;
			MPCRF_OFF_FILTER: next_rdata = {{(8 - MPCRF_F_WIDTH){1'b0}}, filter_mode};
			MPCRF_OFF_BURST: next_rdata = burst_thresh;
			default: next_rdata = MPCRF_ZERO8;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			REG_RDATA <= MPCRF_ZERO8;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
		end
	end

	// ==========================================
	// receive DMA request
	logic [7:0] eff_thresh;
	logic [MPCRF_FIFO_W-1:0] thresh_bytes;
	logic over_thresh;
	logic over_frame;

	assign eff_thresh = (burst_thresh < MPCRF_MIN_BURST) ? MPCRF_MIN_BURST : burst_thresh;
	assign thresh_bytes = {eff_thresh, {MPCRF_UNIT_SHIFT{1'b0}}};
	assign over_thresh = RX_FIFO_USED > thresh_bytes;
	assign over_frame = RX_FIFO_USED > DESCRIPTOR_FRAME_LENGTH;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RX_DMA_REQ <= 1'b0;
		end else begin
			RX_DMA_REQ <= over_thresh || over_frame || RX_URGENT_REQ;
		end
	end

	// ==========================================
	// address filter
	mpcrf_filt_if fbus ();

	assign fbus.da = RX_DA;
	assign fbus.da_valid = RX_DA_VALID;
	assign fbus.station = OWN_MAC_ADDRESS;
	assign fbus.hash_hit = GROUP_HASH_HIT;
	assign fbus.mode = filter_mode;

	mpcrf_filter u_filter (
		.clk(CLK),
		.resetn(RESETN),
		.fi(fbus.filt)
	);

	assign RX_ACCEPT = fbus.accept;
	assign RX_ACCEPT_VALID = fbus.accept_valid;

	// ==========================================
	// checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	property p_mdc;
		wr_phy |=> MDC == $past(REG_WDATA[MPCRF_B_CLK]);
	endproperty
	a_mdc: assert property (p_mdc) else $error("management clock not following bit 0");

	property p_drive;
		wr_phy && REG_WDATA[MPCRF_B_DIR] |=> MDIO_OE && MDIO_O == $past(REG_WDATA[MPCRF_B_DATA]);
	endproperty
	a_drive: assert property (p_drive) else $error("data line not driven with data bit");

	property p_release;
		wr_phy && !REG_WDATA[MPCRF_B_DIR] |=> !MDIO_OE;
	endproperty
	a_release: assert property (p_release) else $error("data line not released");

	property p_read_in;
		REG_RD && REG_ADDR == MPCRF_OFF_PHY && !phy_ctrl[MPCRF_B_DIR]
			|=> REG_RDATA[MPCRF_B_DATA] == $past(MDIO_I);
	endproperty
	a_read_in: assert property (p_read_in) else $error("data bit not reading PHY level");

	property p_duplex;
		REG_RD && REG_ADDR == MPCRF_OFF_PHY
			|=> REG_RDATA[MPCRF_B_DUPLEX] == ($past(PHY_DUPLEX) ~^ $past(phy_ctrl[MPCRF_B_POL]));
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex flag sense wrong");

	property p_status;
		REG_RD && REG_ADDR == MPCRF_OFF_PHY
			|=> REG_RDATA[MPCRF_B_SPEED] == $past(PHY_SPEED)
			&& REG_RDATA[MPCRF_B_LINK] == $past(PHY_LINK);
	endproperty
	a_status: assert property (p_status) else $error("speed or link flag wrong");

	property p_reserved;
		REG_RD && REG_ADDR == MPCRF_OFF_PHY |=> REG_RDATA[MPCRF_B_RSV] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit reads one");

	property p_frame_req;
		RX_FIFO_USED > DESCRIPTOR_FRAME_LENGTH |=> RX_DMA_REQ;
	endproperty
	a_frame_req: assert property (p_frame_req) else $error("no request past frame length");

	property p_min_thresh;
		burst_thresh < MPCRF_MIN_BURST && !RX_URGENT_REQ
			&& RX_FIFO_USED <= {MPCRF_MIN_BURST, {MPCRF_UNIT_SHIFT{1'b0}}}
			&& RX_FIFO_USED <= DESCRIPTOR_FRAME_LENGTH |=> !RX_DMA_REQ;
	endproperty
	a_min_thresh: assert property (p_min_thresh) else $error("low threshold not raised");

	property p_thresh;
		RX_FIFO_USED > thresh_bytes |=> RX_DMA_REQ;
	endproperty
	a_thresh: assert property (p_thresh) else $error("no request over threshold");

	property p_urgent;
		RX_URGENT_REQ |=> RX_DMA_REQ;
	endproperty
	a_urgent: assert property (p_urgent) else $error("urgent request ignored");

	// ==========================================
	// further checks: pins, read view, filter criteria, request floor
	property p_mgmt_hold;
		!wr_phy |=> $stable(MDC) && $stable(MDIO_O) && $stable(MDIO_OE);
	endproperty
	a_mgmt_hold: assert property (p_mgmt_hold) else $error("pins moved");

	property p_release_line;
		!phy_ctrl[MPCRF_B_DIR] |-> !MDIO_OE;
	endproperty
	a_release_line: assert property (p_release_line) else $error("line driven");

	property p_read_out;
		REG_RD && REG_ADDR == MPCRF_OFF_PHY && phy_ctrl[MPCRF_B_DIR]
			|=> REG_RDATA[MPCRF_B_DATA] == $past(phy_ctrl[MPCRF_B_DATA]);
	endproperty
	a_read_out: assert property (p_read_out) else $error("driven data bit misread");

	property p_sense_store;
		wr_phy |=> phy_ctrl[MPCRF_B_POL] == $past(REG_WDATA[MPCRF_B_POL]);
	endproperty
	a_sense_store: assert property (p_sense_store) else $error("sense not stored");

	property p_filter_read;
		REG_RD && REG_ADDR == MPCRF_OFF_FILTER
			|=> REG_RDATA[MPCRF_F_WIDTH-1:0] == $past(filter_mode)
			&& (REG_RDATA >> MPCRF_F_WIDTH) == MPCRF_ZERO8;
	endproperty
	a_filter_read: assert property (p_filter_read) else $error("filter misread");

	property p_unmapped;
		REG_RD && REG_ADDR != MPCRF_OFF_PHY && REG_ADDR != MPCRF_OFF_FILTER
			&& REG_ADDR != MPCRF_OFF_BURST |=> REG_RDATA == MPCRF_ZERO8;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

	property p_raw_thresh;
		wr_burst |=> burst_thresh == $past(REG_WDATA);
	endproperty
	a_raw_thresh: assert property (p_raw_thresh) else $error("threshold altered");

	property p_burst_read;
		REG_RD && REG_ADDR == MPCRF_OFF_BURST |=> REG_RDATA == $past(burst_thresh);
	endproperty
	a_burst_read: assert property (p_burst_read) else $error("threshold misread");

	property p_thresh_quiet;
		burst_thresh >= MPCRF_MIN_BURST && !RX_URGENT_REQ
			&& RX_FIFO_USED <= {burst_thresh, {MPCRF_UNIT_SHIFT{1'b0}}}
			&& RX_FIFO_USED <= DESCRIPTOR_FRAME_LENGTH |=> !RX_DMA_REQ;
	endproperty
	a_thresh_quiet: assert property (p_thresh_quiet) else $error("early request");

	property p_station;
		RX_DA_VALID && filter_mode[MPCRF_F_STATION]
			&& RX_DA == OWN_MAC_ADDRESS |=> RX_ACCEPT;
	endproperty
	a_station: assert property (p_station) else $error("station frame rejected");

	property p_group;
		RX_DA_VALID && filter_mode[MPCRF_F_GROUP] && RX_DA[MPCRF_DA_GROUP_BIT] |=> RX_ACCEPT;
	endproperty
	a_group: assert property (p_group) else $error("group frame rejected");

	property p_bcast;
		RX_DA_VALID && filter_mode[MPCRF_F_BCAST] && RX_DA == MPCRF_ALL_ONES_DA |=> RX_ACCEPT;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast frame rejected");

	property p_hash;
		RX_DA_VALID && filter_mode[MPCRF_F_HASH] && GROUP_HASH_HIT |=> RX_ACCEPT;
	endproperty
	a_hash: assert property (p_hash) else $error("hash match rejected");

	property p_verdict;
		RX_DA_VALID |=> RX_ACCEPT_VALID;
	endproperty
	a_verdict: assert property (p_verdict) else $error("verdict pulse missing");

	property p_verdict_gap;
		!RX_DA_VALID |=> !RX_ACCEPT_VALID;
	endproperty
	a_verdict_gap: assert property (p_verdict_gap) else $error("spurious verdict pulse");

	c_mgmt_read: cover property (wr_phy && !REG_WDATA[MPCRF_B_DIR] ##1 REG_RD
		&& REG_ADDR == MPCRF_OFF_PHY);
	c_burst_req: cover property (!RX_DMA_REQ ##1 over_thresh ##1 RX_DMA_REQ);
	c_accept: cover property (RX_ACCEPT_VALID && RX_ACCEPT);
	c_urgent: cover property (RX_URGENT_REQ && !over_thresh && !over_frame ##1 RX_DMA_REQ);
endmodule

// ---- mpcrf_phy_model.sv ----
// behavioural management-side PHY: resolves the shared data wire
// assumes a pull-up on the wire and a PHY that turns on each management clock rise
module mpcrf_phy_model (
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	output logic mdio_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// phy drive pattern
	logic [2:0] st = 3'h5;
	always @(posedge mdc) begin
		st <= {st[1:0], st[2] ^ st[1]};
	end
	// ==========================================
	// wire resolution: host drive, else phy drive, else pull-up
	assign mdio_i = mdio_oe ? mdio_o : (st[0] ? st[1] : 1'b1);
endmodule

// ---- mac_phy_ctrl_rx_filter_regs_bench.sv ----
// self-checking bench for the management, filter and burst registers
// assumes byte register strobes sampled on the rising clock, read data one cycle later
module mac_phy_ctrl_rx_filter_regs_bench
	import mpcrf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 0, RESETN = 0, REG_WR = 0, REG_RD = 0;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
	logic MDC, MDIO_I, MDIO_O, MDIO_OE, RX_ACCEPT, RX_ACCEPT_VALID, RX_DMA_REQ;
	logic PHY_DUPLEX = 0, PHY_SPEED = 0, PHY_LINK = 0, RX_DA_VALID = 0;
	logic GROUP_HASH_HIT = 0, RX_URGENT_REQ = 0;
	logic [47:0] OWN_MAC_ADDRESS = 48'h0, RX_DA = 48'h0, s;
	logic [MPCRF_FIFO_W-1:0] RX_FIFO_USED = 0, DESCRIPTOR_FRAME_LENGTH = 0;
	logic [31:0] seed = 32'h44587C6F, r, t;
	logic w;
	logic [7:0] x;
	int n_mismatch = 0, num_checks = 0, e;

	mpcrf_bank DUT (.CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MDC(MDC),
		.MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .PHY_DUPLEX(PHY_DUPLEX),
		.PHY_SPEED(PHY_SPEED), .PHY_LINK(PHY_LINK), .OWN_MAC_ADDRESS(OWN_MAC_ADDRESS),
		.RX_DA(RX_DA), .RX_DA_VALID(RX_DA_VALID), .GROUP_HASH_HIT(GROUP_HASH_HIT),
		.RX_ACCEPT(RX_ACCEPT), .RX_ACCEPT_VALID(RX_ACCEPT_VALID), .RX_FIFO_USED(RX_FIFO_USED),
		.DESCRIPTOR_FRAME_LENGTH(DESCRIPTOR_FRAME_LENGTH), .RX_URGENT_REQ(RX_URGENT_REQ),
		.RX_DMA_REQ(RX_DMA_REQ));
	mpcrf_phy_model phy (.mdc(MDC), .mdio_o(MDIO_O), .mdio_oe(MDIO_OE), .mdio_i(MDIO_I));

	// ==========================================
	// clock, helpers
	initial begin
		forever #12.5 CLK = ~CLK;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic fexp(logic [5:0] m, logic [47:0] da, logic [47:0] st, logic h);
		return (m[0] && da == st) || (m[1] && da[40]) || (m[2] && da == 48'hFFFFFFFFFFFF)
			|| m[3] || (m[4] && h) || (m[5] && da[47:24] == 24'h01005E);
	endfunction

	function automatic logic dexp(logic [7:0] th, logic [12:0] u, logic [12:0] fl, logic urg);
		int eff;
		eff = (th < 8) ? 8 : th;
		return (u > eff * 32) || (u > fl) || urg;
	endfunction

	// one strobe cycle; strobes stay up until the next call or bus_idle
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		REG_WR = wr;
		REG_RD = !wr;
		REG_ADDR = a;
		REG_WDATA = d;
		@(posedge CLK);
		#1;
	endtask

	// drops the strobes once the bus has nothing more to do
	task automatic bus_idle();
		REG_WR = 0;
		REG_RD = 0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge CLK);
		n_mismatch++;
		tally_and_finish();
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge CLK);
		#1;
		RESETN = 1;
		xfer(0, MPCRF_OFF_BURST, 8'h00);
		chk(REG_RDATA, 8'h08);
		xfer(0, MPCRF_OFF_FILTER, 8'h00);
		chk(REG_RDATA, 8'h00);
		xfer(1, 8'h33, 8'hFF);
		xfer(0, 8'h33, 8'h00);
		chk(REG_RDATA, 8'h00);
		for (int i = 0; i < 150; i++) begin
			r = xs();
			{PHY_LINK, PHY_SPEED, PHY_DUPLEX} = r[10:8];
			xfer(1, MPCRF_OFF_PHY, r[7:0]);
			chk(MDC, r[0]);
			chk(MDIO_OE, r[2]);
			chk(MDIO_O, r[1]);
			w = MDIO_I;
			xfer(0, MPCRF_OFF_PHY, 8'h00);
			x = {PHY_LINK, PHY_SPEED, ~(PHY_DUPLEX ^ r[4]), r[4], 1'b0, r[2],
				r[2] ? r[1] : w, r[0]};
			chk(REG_RDATA, x);
		end
		for (int i = 0; i < 200; i++) begin
			r = xs();
			xfer(1, MPCRF_OFF_FILTER, r[7:0]);
			xfer(0, MPCRF_OFF_FILTER, 8'h00);
			chk(REG_RDATA, r[7:0] & 8'h3F);
			bus_idle();
			s = 48'({xs(), xs()});
			OWN_MAC_ADDRESS = {s[15:0], xs()};
			case (r[10:8])
				0: RX_DA = OWN_MAC_ADDRESS;
				1: RX_DA = 48'hFFFFFFFFFFFF;
				2: RX_DA = {24'h01005E, s[23:0]};
				3: RX_DA = s | 48'h010000000000;
				default: RX_DA = s & 48'hFEFFFFFFFFFF;
			endcase
			GROUP_HASH_HIT = r[11];
			RX_DA_VALID = 1;
			@(posedge CLK);
			#1;
			RX_DA_VALID = 0;
			x = {7'h00, fexp(r[5:0], RX_DA, OWN_MAC_ADDRESS, r[11])};
			chk(RX_ACCEPT_VALID, 1);
			chk(RX_ACCEPT, x);
			@(posedge CLK);
			#1;
			chk(RX_ACCEPT_VALID, 0);
		end
		for (int i = 0; i < 200; i++) begin
			r = xs();
			t = xs();
			if (r[8])
				r[7:0] = {5'h00, r[2:0]};
			xfer(1, MPCRF_OFF_BURST, r[7:0]);
			xfer(0, MPCRF_OFF_BURST, 8'h00);
			chk(REG_RDATA, r[7:0]);
			bus_idle();
			e = (r[7:0] < 8) ? 8 : r[7:0];
			RX_FIFO_USED = r[9] ? t[12:0] : 13'(e * 32 + r[11:10] - 1);
			DESCRIPTOR_FRAME_LENGTH = r[12] ? 13'h1FFF : t[28:16];
			RX_URGENT_REQ = (r[14:13] == 2'h0);
			@(posedge CLK);
			#1;
			x = {7'h00, dexp(r[7:0], RX_FIFO_USED, DESCRIPTOR_FRAME_LENGTH, RX_URGENT_REQ)};
			chk(RX_DMA_REQ, x);
		end
		tally_and_finish();
	end
endmodule
